/* File: rtl/rcr_pkg.sv */
package rcr_pkg;
   // register byte addresses on the processor data bus
   localparam logic [19:0] ADDR_POWER_ON_STATUS = 20'hf00f9;
   localparam logic [19:0] ADDR_RESET_CAUSE_FLAGS = 20'hfffa8;
   localparam logic [19:0] ADDR_PARITY_CTRL = 20'hf0160;

   // reset cause flag positions
   localparam int BIT_TRAP = 7;
   localparam int BIT_WATCHDOG = 4;
   localparam int BIT_PARITY = 2;
   localparam int BIT_ACCESS = 1;
   localparam int BIT_UNDERVOLT = 0;
   localparam logic [7:0] FLAG_MASK = 8'h97;

   // power-on status and parity control field positions
   localparam int BIT_POWERON_ABSENT = 0;
   localparam int BIT_PARITY_DISABLE = 0;

   // values after reset
   localparam logic [7:0] RST_FLAGS = 8'h00;
   localparam logic [7:0] RST_STATUS = 8'h00;
   localparam logic RST_PARITY_DISABLE = 1'b0;
   localparam logic [7:0] RST_RDATA = 8'h00;

   // opcode that requests the illegal-instruction reset
   localparam logic [7:0] OPCODE_TRAP = 8'hff;

   // pin synchroniser lanes: external reset, rise and fall comparators
   localparam int SYNC_W = 3;
   localparam int LANE_EXT = 0;
   localparam int LANE_RISE = 1;
   localparam int LANE_FALL = 2;
   localparam logic [2:0] RST_SYNC = 3'h1;
   localparam int SYNC_STAGES = 2;

   // power-on detector state
   typedef enum logic [1:0] {
      RCR_POR_HOLD = 2'b01,
      RCR_POR_RUN = 2'b10
   } rcr_por_e;
endpackage

/* File: rtl/rcr_sync_if.sv */
`timescale 1ns/1ps
interface rcr_sync_if;
   logic [2:0] raw;
   logic [2:0] sync;
   modport sync_side (input raw, output sync);
   modport user (output raw, input sync);
endinterface

/* File: rtl/rcr_sync.sv */
`timescale 1ns/1ps
module rcr_sync (
   input wire logic clk,
   input wire logic rst_n,
   rcr_sync_if.sync_side lanes
);
   logic [2:0] meta_q;
   logic [2:0] hold_q;

   ///////////////////////////////////////////////////////////////////////
   // two flip-flop synchroniser; first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= rcr_pkg::RST_SYNC;
         hold_q <= rcr_pkg::RST_SYNC;
      end else begin
         meta_q <= lanes.raw;
         hold_q <= meta_q;
      end
   end

   assign lanes.sync = hold_q;
endmodule

/* File: rtl/rcr_top.sv */
`timescale 1ns/1ps
// Contract
// - opcode FFH execution sets trap flag
// - no trap reset under debug emulation
// - watchdog request sets watchdog flag
// - parity error request sets parity flag
// - illegal access request sets access flag
// - voltage detector request sets undervoltage flag
// - internal source sets own flag, others held
// - power-on reset clears both registers
// - external reset pin clears all cause flags
// - byte read returns then clears flags
// - every reset re-enables parity resets
// - writing one sets absent flag, zero ignored
// - status cleared only by power-on reset
// - absent flag one means no power-on since
// - hold reset until rise comparator passes
// - assert reset when fall comparator trips
module rcr_top (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [19:0] addr,
   input wire logic rd_en,
   input wire logic wr_en,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   input wire logic op_valid,
   input wire logic [7:0] opcode,
   input wire logic debug_active,
   input wire logic watchdog_req,
   input wire logic parity_err,
   input wire logic bad_access_req,
   input wire logic voltage_detector_req,
   input wire logic ext_reset_b,
   input wire logic rise_ok,
   input wire logic fall_low,
   output logic internal_reset,
   output logic por_reset
);
   logic rst_meta_q;
   logic rst_n_q;
   logic [7:0] reset_cause_flags_q;
   logic [7:0] power_on_status_q;
   logic parity_reset_disable_q;
   logic [7:0] rdata_q;
   logic internal_reset_q;
   rcr_pkg::rcr_por_e por_state_q;
   logic [7:0] set_vec;
   logic trap_req;
   logic parity_req;
   logic any_req;
   logic ext_active;
   logic por_active;
   logic rd_flags;
   logic wr_status;
   logic wr_parity;
   rcr_sync_if sync_lanes ();

   ///////////////////////////////////////////////////////////////////////
   // reset release through two flip-flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // pins from outside the clock domain
   assign sync_lanes.raw = {fall_low, rise_ok, ext_reset_b};

   rcr_sync u_sync (
      .clk(clk),
      .rst_n(rst_n_q),
      .lanes(sync_lanes)
   );

   assign ext_active = !sync_lanes.sync[rcr_pkg::LANE_EXT];
   assign por_active = (por_state_q == rcr_pkg::RCR_POR_HOLD);

   ///////////////////////////////////////////////////////////////////////
   // power-on detector: held after power-up, re-entered on supply fall
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         por_state_q <= rcr_pkg::RCR_POR_HOLD;
      end else begin
         case (por_state_q)
            rcr_pkg::RCR_POR_HOLD: begin
               if (sync_lanes.sync[rcr_pkg::LANE_RISE] && !sync_lanes.sync[rcr_pkg::LANE_FALL]) begin
                  por_state_q <= rcr_pkg::RCR_POR_RUN;
               end
            end
            rcr_pkg::RCR_POR_RUN: begin
               if (sync_lanes.sync[rcr_pkg::LANE_FALL]) begin
                  por_state_q <= rcr_pkg::RCR_POR_HOLD;
               end
            end
            default: begin
               por_state_q <= rcr_pkg::RCR_POR_HOLD;
            end
         endcase
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // internal reset sources and register strobes
   assign trap_req = op_valid && (opcode == rcr_pkg::OPCODE_TRAP) && !debug_active;
   assign parity_req = parity_err && !parity_reset_disable_q;
   assign any_req = trap_req || watchdog_req || parity_req || bad_access_req || voltage_detector_req;
   assign rd_flags = rd_en && (addr == rcr_pkg::ADDR_RESET_CAUSE_FLAGS);
   assign wr_status = wr_en && (addr == rcr_pkg::ADDR_POWER_ON_STATUS);
   assign wr_parity = wr_en && (addr == rcr_pkg::ADDR_PARITY_CTRL);

   // per-source set vector in the documented bit layout
   always_comb begin
      set_vec = 8'h00;
      set_vec[rcr_pkg::BIT_TRAP] = trap_req;
      set_vec[rcr_pkg::BIT_WATCHDOG] = watchdog_req;
      set_vec[rcr_pkg::BIT_PARITY] = parity_req;
      set_vec[rcr_pkg::BIT_ACCESS] = bad_access_req;
      set_vec[rcr_pkg::BIT_UNDERVOLT] = voltage_detector_req;
   end

   ///////////////////////////////////////////////////////////////////////
   // reset cause flags: pin and power-on clear, sources set, read clears
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         reset_cause_flags_q <= rcr_pkg::RST_FLAGS;
      end else if (por_active || ext_active) begin
         reset_cause_flags_q <= rcr_pkg::RST_FLAGS;
      end else if (rd_flags) begin
         reset_cause_flags_q <= set_vec & rcr_pkg::FLAG_MASK;
      end else begin
         reset_cause_flags_q <= (reset_cause_flags_q | set_vec) & rcr_pkg::FLAG_MASK;
      end
   end

   // power-on status: write one sets, only power-on clears
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         power_on_status_q <= rcr_pkg::RST_STATUS;
      end else if (por_active) begin
         power_on_status_q <= rcr_pkg::RST_STATUS;
      end else if (wr_status && wdata[rcr_pkg::BIT_POWERON_ABSENT]) begin
         power_on_status_q[rcr_pkg::BIT_POWERON_ABSENT] <= 1'b1;
      end
   end

   // parity reset disable: any reset returns it to enabled
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         parity_reset_disable_q <= rcr_pkg::RST_PARITY_DISABLE;
      end else if (internal_reset_q) begin
         parity_reset_disable_q <= rcr_pkg::RST_PARITY_DISABLE;
      end else if (wr_parity) begin
         parity_reset_disable_q <= wdata[rcr_pkg::BIT_PARITY_DISABLE];
      end
   end

   ///////////////////////////////////////////////////////////////////////
   // read data: value held before any clear; unmapped reads zero
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdata_q <= rcr_pkg::RST_RDATA;
      end else if (rd_flags) begin
         rdata_q <= reset_cause_flags_q;
      end else if (rd_en && (addr == rcr_pkg::ADDR_POWER_ON_STATUS)) begin
         rdata_q <= power_on_status_q;
      end else if (rd_en && (addr == rcr_pkg::ADDR_PARITY_CTRL)) begin
         rdata_q <= {7'h00, parity_reset_disable_q};
      end else begin
         rdata_q <= rcr_pkg::RST_RDATA;
      end
   end

   // internal reset: detector hold, pin, or one cycle per source request
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         internal_reset_q <= 1'b1;
      end else begin
         internal_reset_q <= por_active || ext_active || any_req;
      end
   end

   assign rdata = rdata_q;
   assign internal_reset = internal_reset_q;
   assign por_reset = por_state_q[0];

   ///////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n_q);

   a_trap_flag_set: assert property (
      trap_req && !por_active && !ext_active |=> reset_cause_flags_q[rcr_pkg::BIT_TRAP])
      else $error("trap flag not set after opcode request");

   a_debug_no_trap: assert property (
      op_valid && opcode == rcr_pkg::OPCODE_TRAP && debug_active && !reset_cause_flags_q[rcr_pkg::BIT_TRAP]
      |=> !reset_cause_flags_q[rcr_pkg::BIT_TRAP])
      else $error("trap flag set under debug");

   a_watchdog_flag_set: assert property (
      watchdog_req && !por_active && !ext_active |=> reset_cause_flags_q[rcr_pkg::BIT_WATCHDOG])
      else $error("watchdog flag not set");

   a_parity_flag_set: assert property (
      parity_err && !parity_reset_disable_q && !por_active && !ext_active
      |=> reset_cause_flags_q[rcr_pkg::BIT_PARITY] && internal_reset_q)
      else $error("parity flag not set");

   a_access_flag_set: assert property (
      bad_access_req && !por_active && !ext_active |=> reset_cause_flags_q[rcr_pkg::BIT_ACCESS])
      else $error("access flag not set");

   a_undervolt_set: assert property (
      voltage_detector_req && !por_active && !ext_active |=> reset_cause_flags_q[rcr_pkg::BIT_UNDERVOLT])
      else $error("undervoltage flag not set");

   a_others_held: assert property (
      any_req && !rd_flags && !por_active && !ext_active
      |=> (reset_cause_flags_q & ~$past(set_vec)) == ($past(reset_cause_flags_q) & ~$past(set_vec)))
      else $error("unrelated flag changed on source reset");

   a_por_clears: assert property (
      por_active |=> reset_cause_flags_q == 8'h00 && power_on_status_q == 8'h00)
      else $error("power-on did not clear registers");

   a_pin_clears: assert property (
      ext_active |=> reset_cause_flags_q == 8'h00 && internal_reset_q)
      else $error("external reset did not clear flags");

   a_read_clears: assert property (
      rd_flags && !any_req && !por_active && !ext_active
      |=> reset_cause_flags_q == 8'h00 && rdata_q == $past(reset_cause_flags_q))
      else $error("flag read did not return and clear");

   a_parity_reenable: assert property (
      internal_reset_q |=> !parity_reset_disable_q)
      else $error("parity reset not re-enabled after reset");

   a_absent_set: assert property (
      wr_status && wdata[rcr_pkg::BIT_POWERON_ABSENT] && !por_active
      |=> power_on_status_q == 8'h01)
      else $error("write one did not set absent flag");

   a_status_kept: assert property (
      power_on_status_q[rcr_pkg::BIT_POWERON_ABSENT] && !por_active
      |=> power_on_status_q[rcr_pkg::BIT_POWERON_ABSENT])
      else $error("status lost without power-on reset");

   a_por_release: assert property (
      por_active && sync_lanes.sync[rcr_pkg::LANE_RISE] && !sync_lanes.sync[rcr_pkg::LANE_FALL]
      |=> !por_active ##1 (!internal_reset_q || $past(ext_active) || $past(any_req)))
      else $error("power-on hold not released");

   a_por_fall: assert property (
      sync_lanes.sync[rcr_pkg::LANE_FALL] |=> por_active ##1 internal_reset_q)
      else $error("supply fall did not assert reset");

   a_unused_zero: assert property (
      1'b1 |-> (reset_cause_flags_q & ~rcr_pkg::FLAG_MASK) == 8'h00)
      else $error("reserved flag bit set");

   ///////////////////////////////////////////////////////////////////////
   // parity mask, pin side effects and status layout
   a_parity_masked: assert property (
      parity_err && parity_reset_disable_q && !reset_cause_flags_q[rcr_pkg::BIT_PARITY]
      |=> !reset_cause_flags_q[rcr_pkg::BIT_PARITY])
      else $error("parity flag set while parity resets disabled");

   a_source_resets: assert property (
      any_req |=> internal_reset_q)
      else $error("source request did not raise internal reset");

   a_pin_parity: assert property (
      ext_active |-> ##2 !parity_reset_disable_q)
      else $error("pin reset did not re-enable parity resets");

   a_pin_keeps_status: assert property (
      ext_active && !por_active && !wr_status
      |=> power_on_status_q == $past(power_on_status_q))
      else $error("pin reset changed power-on status");

   a_status_upper_zero: assert property (
      1'b1 |-> power_on_status_q[7:1] == 7'h00)
      else $error("reserved status bit set");

   a_set_beats_read: assert property (
      rd_flags && any_req && !por_active && !ext_active
      |=> reset_cause_flags_q == ($past(set_vec) & rcr_pkg::FLAG_MASK))
      else $error("source set lost to read clear");

   // main scenarios reached
   c_trap_read: cover property (trap_req ##2 rd_flags ##1 rdata_q[rcr_pkg::BIT_TRAP]);
   c_absent_write: cover property (wr_status && wdata[0] ##1 power_on_status_q[0]);
   c_por_cycle: cover property (!por_active ##1 por_active ##[1:20] !por_active);
   c_set_on_read: cover property (rd_flags && watchdog_req ##1 reset_cause_flags_q[rcr_pkg::BIT_WATCHDOG]);
   c_pin_cycle: cover property (ext_active ##1 reset_cause_flags_q == 8'h00 ##[1:10] !ext_active);
endmodule

/* File: tb/rcr_src_model.sv */
`timescale 1ns/1ps
// on-chip reset request sources: one pulse per fire, chosen by sel
module rcr_src_model (
   input wire logic fire,
   input wire logic [2:0] sel,
   output logic op_valid,
   output logic [7:0] opcode,
   output logic watchdog_req,
   output logic parity_err,
   output logic bad_access_req,
   output logic voltage_detector_req
);
   // sel 0 trap opcode, 1 watchdog, 2 parity, 3 access, 4 undervoltage, 5 harmless opcode
   // parity pulses only on request, as if the used ram had been initialised
   always_comb begin
      op_valid = fire && (sel == 3'h0 || sel == 3'h5);
      opcode = (sel == 3'h0) ? 8'hff : 8'hfe;
      watchdog_req = fire && sel == 3'h1;
      parity_err = fire && sel == 3'h2;
      bad_access_req = fire && sel == 3'h3;
      voltage_detector_req = fire && sel == 3'h4;
   end
endmodule

/* File: tb/reset_cause_recorder_tb.sv */
`timescale 1ns/1ps
module reset_cause_recorder_tb;
   logic clk, rst_b, rd_en, wr_en, debug_active, ext_reset_b, rise_ok, fall_low, fire;
   logic [19:0] addr;
   logic [7:0] wdata, rdata, opcode;
   logic [2:0] sel;
   logic op_valid, watchdog_req, parity_err, bad_access_req, voltage_detector_req, internal_reset, por_reset;
   logic [7:0] flag_tbl [5] = '{8'h80, 8'h10, 8'h04, 8'h02, 8'h01};
   int error_cnt = 0;
   int num_checks = 0;
   ////////////////////////////////////////////////////////////////////////////
   rcr_top rcr_top_inst (.clk(clk), .rst_b(rst_b), .addr(addr), .rd_en(rd_en), .wr_en(wr_en),
      .wdata(wdata), .rdata(rdata), .op_valid(op_valid), .opcode(opcode), .debug_active(debug_active),
      .watchdog_req(watchdog_req), .parity_err(parity_err), .bad_access_req(bad_access_req),
      .voltage_detector_req(voltage_detector_req), .ext_reset_b(ext_reset_b), .rise_ok(rise_ok),
      .fall_low(fall_low), .internal_reset(internal_reset), .por_reset(por_reset));
   rcr_src_model rcr_src_model_inst (.fire(fire), .sel(sel), .op_valid(op_valid), .opcode(opcode),
      .watchdog_req(watchdog_req), .parity_err(parity_err), .bad_access_req(bad_access_req),
      .voltage_detector_req(voltage_detector_req));
   ////////////////////////////////////////////////////////////////////////////
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // compare and count
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // counts, verdict, end of run
   task give_verdict;
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task step;
      @(posedge clk);
      #1;
   endtask
   // byte write
   task wr(input logic [19:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      step();
      wr_en = 1'b0;
      step();
   endtask
   // byte-wide read only, never a single-bit read
   task rd(input logic [19:0] a, input logic [7:0] e);
      addr = a;
      rd_en = 1'b1;
      step();
      rd_en = 1'b0;
      chk(rdata, e);
      step();
   endtask
   // one source pulse, then the internal reset it should cause
   task fire_src(input logic [2:0] s, input logic ir);
      sel = s;
      fire = 1'b1;
      step();
      fire = 1'b0;
      chk({7'h00, internal_reset}, {7'h00, ir});
      step();
   endtask
   // bounded wait for the power-on detector state
   task wait_por(input logic v);
      for (int i = 0; i < 30; i++) begin
         if (por_reset === v)
            break;
         step();
      end
      chk({7'h00, por_reset}, {7'h00, v});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // tests take about 130 cycles; cut off well beyond
   initial begin
      #100000;
      error_cnt++;
      give_verdict();
   end
   // main sequence
   initial begin
      rst_b = 1'b0;
      {rd_en, wr_en, debug_active, rise_ok, fall_low, fire} = 6'h00;
      ext_reset_b = 1'b1;
      addr = 20'h00000;
      wdata = 8'h00;
      sel = 3'h0;
      repeat (10) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (8) step();
      chk({7'h00, por_reset}, 8'h01);
      rise_ok = 1'b1;
      wait_por(1'b0);
      rd(rcr_pkg::ADDR_RESET_CAUSE_FLAGS, 8'h00);
      rd(rcr_pkg::ADDR_POWER_ON_STATUS, 8'h00);
      for (int i = 0; i < 5; i++) begin
         fire_src(i[2:0], 1'b1);
         rd(rcr_pkg::ADDR_RESET_CAUSE_FLAGS, flag_tbl[i]);
         rd(rcr_pkg::ADDR_RESET_CAUSE_FLAGS, 8'h00);
      end
      fire_src(3'h1, 1'b1);
      fire_src(3'h0, 1'b1);
      rd(rcr_pkg::ADDR_RESET_CAUSE_FLAGS, 8'h90);
      debug_active = 1'b1;
      fire_src(3'h0, 1'b0);
      debug_active = 1'b0;
      fire_src(3'h5, 1'b0);
      rd(rcr_pkg::ADDR_RESET_CAUSE_FLAGS, 8'h00);
      wr(rcr_pkg::ADDR_POWER_ON_STATUS, 8'h00);
      rd(rcr_pkg::ADDR_POWER_ON_STATUS, 8'h00);
      wr(rcr_pkg::ADDR_POWER_ON_STATUS, 8'h01);
      rd(rcr_pkg::ADDR_POWER_ON_STATUS, 8'h01);
      wr(rcr_pkg::ADDR_POWER_ON_STATUS, 8'h00);
      rd(rcr_pkg::ADDR_POWER_ON_STATUS, 8'h01);
      wr(rcr_pkg::ADDR_RESET_CAUSE_FLAGS, 8'hff);
      rd(rcr_pkg::ADDR_RESET_CAUSE_FLAGS, 8'h00);
      rd(20'h00010, 8'h00);
      wr(rcr_pkg::ADDR_PARITY_CTRL, 8'h01);
      rd(rcr_pkg::ADDR_PARITY_CTRL, 8'h01);
      fire_src(3'h2, 1'b0);
      fire_src(3'h1, 1'b1);
      rd(rcr_pkg::ADDR_PARITY_CTRL, 8'h00);
      rd(rcr_pkg::ADDR_RESET_CAUSE_FLAGS, 8'h10);
      fire_src(3'h3, 1'b1);
      wr(rcr_pkg::ADDR_PARITY_CTRL, 8'h01);
      ext_reset_b = 1'b0;
      repeat (6) step();
      chk({7'h00, internal_reset}, 8'h01);
      ext_reset_b = 1'b1;
      repeat (6) step();
      rd(rcr_pkg::ADDR_RESET_CAUSE_FLAGS, 8'h00);
      rd(rcr_pkg::ADDR_POWER_ON_STATUS, 8'h01);
      rd(rcr_pkg::ADDR_PARITY_CTRL, 8'h00);
      fire_src(3'h4, 1'b1);
      fall_low = 1'b1;
      wait_por(1'b1);
      fall_low = 1'b0;
      wait_por(1'b0);
      rd(rcr_pkg::ADDR_RESET_CAUSE_FLAGS, 8'h00);
      rd(rcr_pkg::ADDR_POWER_ON_STATUS, 8'h00);
      give_verdict();
   end
endmodule
